// ==== core/byte_fifo_pkg.sv ====
// Constants shared by the byte FIFO register block and its helpers
//
// Summary of operation
// [RULE1] Depth select bit 7 set gives 255 bytes, clear gives 512 bytes.
// [RULE2] Host changes depth select only after the buffer has been cleared.
// [RULE3] Near-full flag bit 6 is high when depth minus count is within threshold.
// [RULE4] Near-empty flag bit 5 is high when count is within threshold.
// [RULE5] Writing 1 to bit 4 empties the buffer; the bit reads as 0.
// [RULE6] Config bit 2 is threshold bit 8, used only in 512-byte mode.
// [RULE7] Config bits 1:0 show count bits 9:8, read-only, meaningful in 512 mode.
// [RULE8] Threshold register at index 03h holds threshold bits 7:0, read/write.
// [RULE9] Count register at index 04h shows count bits 7:0, reset to 00h.
// [RULE10] Data port write pushes and counts up; read pops and counts down.
// [RULE11] Data port accesses never move the register address pointer.
// [RULE12] Config register at index 02h gathers depth, flags, flush and extensions.
// [RULE13] Rising near-full flag latches a sticky near-full event bit.
// [RULE14] Rising near-empty flag latches a sticky near-empty event bit.
// [RULE15] Write when full is dropped with overflow; read when empty keeps zero.
package byte_fifo_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONFIG  = 8'h02;
  localparam logic [7:0] IDX_THRESH  = 8'h03;
  localparam logic [7:0] IDX_COUNT   = 8'h04;
  localparam logic [7:0] IDX_DATA    = 8'h05;
  localparam logic [7:0] IDX_EVENT   = 8'h06;
  localparam logic [7:0] IDX_MASK    = 8'h07;
  localparam logic [7:0] ADDR_CONFIG = {IDX_CONFIG[5:0], 2'b00};
  localparam logic [7:0] ADDR_THRESH = {IDX_THRESH[5:0], 2'b00};
  localparam logic [7:0] ADDR_COUNT  = {IDX_COUNT[5:0], 2'b00};
  localparam logic [7:0] ADDR_DATA   = {IDX_DATA[5:0], 2'b00};
  localparam logic [7:0] ADDR_EVENT  = {IDX_EVENT[5:0], 2'b00};
  localparam logic [7:0] ADDR_MASK   = {IDX_MASK[5:0], 2'b00};

  // ----------------------------------------------------------------
  // Config register field positions
  // ----------------------------------------------------------------
  localparam int CFG_DEPTH_BIT = 7;
  localparam int CFG_NF_BIT    = 6;
  localparam int CFG_NE_BIT    = 5;
  localparam int CFG_CLEAR_BIT = 4;
  localparam int CFG_TMSB_BIT  = 2;

  // ----------------------------------------------------------------
  // Event register bit positions
  // ----------------------------------------------------------------
  localparam int EVT_W   = 4;
  localparam int EVT_NE  = 0;
  localparam int EVT_NF  = 1;
  localparam int EVT_OVF = 2;
  localparam int EVT_UDF = 3;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int              PTR_W         = 9;
  localparam int              CNT_W         = 10;
  localparam int              MEM_WORDS     = 512;
  localparam logic [9:0]      DEPTH_SMALL   = 10'h0ff;
  localparam logic [9:0]      DEPTH_LARGE   = 10'h200;
  localparam logic            CFG_DEPTH_RST = 1'b0;
  localparam logic            CFG_TMSB_RST  = 1'b0;
  localparam logic [7:0]      THRESH_RST    = 8'h00;
  localparam logic [9:0]      COUNT_RST     = 10'h000;
  localparam logic [3:0]      MASK_RST      = 4'h0;

endpackage

// ==== core/byte_store.sv ====
// Storage array for the byte FIFO with one write and one read port
`timescale 1ns/1ps
`default_nettype none
module byte_store
  import byte_fifo_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [PTR_W-1:0] wr_addr,
  input  wire logic [7:0]       wr_data,
  // Read side
  input  wire logic [PTR_W-1:0] rd_addr,
  output logic      [7:0]       rd_data
);

  // No reset on the array: contents only matter once counted in
  logic [7:0] mem [MEM_WORDS];

  // Synchronous write
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Asynchronous read so the head byte is ready at setup time
  assign rd_data = mem[rd_addr];

endmodule
`default_nettype wire

// ==== core/level_compare.sv ====
// Threshold comparison producing near-full and near-empty levels
`timescale 1ns/1ps
`default_nettype none
module level_compare
  import byte_fifo_pkg::*;
(
  // Configuration
  input  wire logic             depth_sel,
  input  wire logic [7:0]       thr_low,
  input  wire logic             thr_msb,
  // Occupancy
  input  wire logic [CNT_W-1:0] count,
  // Flags
  output logic                  near_full,
  output logic                  near_empty
);

  logic [CNT_W-1:0] depth;
  logic [CNT_W-1:0] level;
  logic [CNT_W-1:0] space;

  // Upper threshold bit only counts in the large mode
  assign depth = depth_sel ? DEPTH_SMALL : DEPTH_LARGE; // [RULE1]
  assign level = {1'b0, thr_msb & ~depth_sel, thr_low}; // [RULE6] [RULE8]
  assign space = depth - count;

  // Count exceeds depth only if depth select is set while more than 255 bytes are held; space then wraps
  assign near_full  = (space <= level); // [RULE3]
  assign near_empty = (count <= level); // [RULE4]

endmodule
`default_nettype wire

// ==== core/rf_frontend_byte_fifo.sv ====
// Byte FIFO with threshold flags, flush and event interrupt behind APB
`timescale 1ns/1ps
`default_nettype none
module rf_frontend_byte_fifo
  import byte_fifo_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  // APB request
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  // APB answer
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Status toward the datapath
  output logic             NEAR_FULL,
  output logic             NEAR_EMPTY,
  // Interrupt
  output logic             IRQ
);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------

  // Bus phase tracking, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC  = 2'b10
  } bus_state_e;

  // Every flip-flop of the block
  typedef struct packed {
    bus_state_e       st;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
    logic             depth_sel;
    logic             thr_msb;
    logic [7:0]       thr_low;
    logic [CNT_W-1:0] count;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic             nf_prev;
    logic             ne_prev;
  } state_s;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  state_s           q_r;
  state_s           q_nxt;
  logic             near_full;
  logic             near_empty;
  logic [7:0]       head_byte;
  logic             push;
  logic             pop;
  logic             flush;
  logic             access;
  logic             wr_ok;
  logic             full;
  logic [CNT_W-1:0] depth;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------

  // Word address match; low two bits must be zero
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    reg_hit = (addr == target);
  endfunction

  // Any register of the map
  function automatic logic mapped(input logic [7:0] addr);
    if (reg_hit(addr, ADDR_CONFIG)) begin
      mapped = 1'b1;
    end else if (reg_hit(addr, ADDR_THRESH)) begin
      mapped = 1'b1;
    end else if (reg_hit(addr, ADDR_COUNT)) begin
      mapped = 1'b1;
    end else if (reg_hit(addr, ADDR_DATA)) begin
      mapped = 1'b1;
    end else if (reg_hit(addr, ADDR_EVENT)) begin
      mapped = 1'b1;
    end else if (reg_hit(addr, ADDR_MASK)) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  endfunction

  // Config word as software sees it
  function automatic logic [7:0] config_word(input state_s s,
                                             input logic nf,
                                             input logic ne);
    logic [7:0] w;
    w = 8'h00;
    w[CFG_DEPTH_BIT] = s.depth_sel;           // [RULE12]
    w[CFG_NF_BIT]    = nf;                    // [RULE3]
    w[CFG_NE_BIT]    = ne;                    // [RULE4]
    w[CFG_CLEAR_BIT] = 1'b0;                  // [RULE5]
    w[CFG_TMSB_BIT]  = s.thr_msb;             // [RULE6]
    w[1:0]           = s.count[CNT_W-1:8];    // [RULE7]
    config_word = w;
  endfunction

  // Read mux; unmapped words read as zero
  function automatic logic [31:0] read_word(input logic [7:0] addr,
                                            input state_s s,
                                            input logic nf,
                                            input logic ne,
                                            input logic [7:0] head);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (reg_hit(addr, ADDR_CONFIG)) begin
      w[7:0] = config_word(s, nf, ne);
    end else if (reg_hit(addr, ADDR_THRESH)) begin
      w[7:0] = s.thr_low;                     // [RULE8]
    end else if (reg_hit(addr, ADDR_COUNT)) begin
      w[7:0] = s.count[7:0];                  // [RULE9]
    end else if (reg_hit(addr, ADDR_DATA)) begin
      // Empty buffer gives zero rather than stale bytes
      w[7:0] = (s.count == COUNT_RST) ? 8'h00 : head;
    end else if (reg_hit(addr, ADDR_EVENT)) begin
      w[EVT_W-1:0] = s.evt;
    end else if (reg_hit(addr, ADDR_MASK)) begin
      w[EVT_W-1:0] = s.mask;
    end
    read_word = w;
  endfunction

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Threshold flags from the registered count
  level_compare u_level (
    .depth_sel  (q_r.depth_sel),
    .thr_low    (q_r.thr_low),
    .thr_msb    (q_r.thr_msb),
    .count      (q_r.count),
    .near_full  (near_full),
    .near_empty (near_empty)
  );

  // Byte array; write lands at the tail pointer
  byte_store u_store (
    .clk     (MCLK),
    .wr_en   (push),
    .wr_addr (q_r.wr_ptr),
    .wr_data (PWDATA[7:0]),
    .rd_addr (q_r.rd_ptr),
    .rd_data (head_byte)
  );

  // ----------------------------------------------------------------
  // Occupancy limits
  // ----------------------------------------------------------------

  // Capacity follows the depth select; the array always holds 512
  assign depth = q_r.depth_sel ? DEPTH_SMALL : DEPTH_LARGE; // [RULE1]
  assign full  = (q_r.count >= depth);

  // Completing access phase and a write with its low byte lane enabled
  assign access = PSEL & PENABLE & q_r.pready;
  assign wr_ok  = access & PWRITE & PSTRB[0];

  // Push and pop strobes; full and empty cases are filtered here
  assign push  = wr_ok & reg_hit(PADDR, ADDR_DATA) & ~full;   // [RULE10] [RULE15]
  assign pop   = access & ~PWRITE & reg_hit(PADDR, ADDR_DATA)
                 & (q_r.count != COUNT_RST);                  // [RULE10] [RULE15]
  assign flush = wr_ok & reg_hit(PADDR, ADDR_CONFIG)
                 & PWDATA[CFG_CLEAR_BIT];                     // [RULE5]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt         = q_r;
    q_nxt.pready  = 1'b0;
    q_nxt.pslverr = 1'b0;

    // Bus phase: answer is prepared during the setup cycle
    case (q_r.st)
      ST_IDLE: begin
        if (PSEL & ~PENABLE) begin
          q_nxt.st      = ST_ACC;
          q_nxt.pready  = 1'b1;
          q_nxt.pslverr = ~mapped(PADDR);
          q_nxt.prdata  = PWRITE ? 32'h0000_0000
                        : read_word(PADDR, q_r, near_full, near_empty, head_byte);
        end
      end
      ST_ACC: begin
        // Ready stands until the master samples it
        if (access) begin
          q_nxt.st = ST_IDLE;
        end else begin
          q_nxt.pready  = q_r.pready;
          q_nxt.pslverr = q_r.pslverr;
        end
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase

    // Register writes; the pointer into the map is never stepped
    if (wr_ok) begin
      if (reg_hit(PADDR, ADDR_CONFIG)) begin
        q_nxt.depth_sel = PWDATA[CFG_DEPTH_BIT];  // [RULE1] [RULE12]
        q_nxt.thr_msb   = PWDATA[CFG_TMSB_BIT];   // [RULE6]
      end else if (reg_hit(PADDR, ADDR_THRESH)) begin
        q_nxt.thr_low = PWDATA[7:0];              // [RULE8]
      end else if (reg_hit(PADDR, ADDR_EVENT)) begin
        q_nxt.evt = q_r.evt & ~PWDATA[EVT_W-1:0];
      end else if (reg_hit(PADDR, ADDR_MASK)) begin
        q_nxt.mask = PWDATA[EVT_W-1:0];
      end
    end

    // Pointers and count; a flush overrides any data movement
    if (flush) begin
      q_nxt.count  = COUNT_RST;                   // [RULE5]
      q_nxt.wr_ptr = '0;
      q_nxt.rd_ptr = '0;
    end else if (push) begin
      q_nxt.count  = q_r.count + 10'h001;         // [RULE10]
      q_nxt.wr_ptr = q_r.wr_ptr + 9'h001;         // [RULE11]
    end else if (pop) begin
      q_nxt.count  = q_r.count - 10'h001;         // [RULE10]
      q_nxt.rd_ptr = q_r.rd_ptr + 9'h001;         // [RULE11]
    end

    // Edge history of the level flags
    q_nxt.nf_prev = near_full;
    q_nxt.ne_prev = near_empty;

    // Sticky events are set after the clear so a set always wins
    if (near_full & ~q_r.nf_prev) begin
      q_nxt.evt[EVT_NF] = 1'b1;                   // [RULE13]
    end
    if (near_empty & ~q_r.ne_prev) begin
      q_nxt.evt[EVT_NE] = 1'b1;                   // [RULE14]
    end
    if (wr_ok & reg_hit(PADDR, ADDR_DATA) & full) begin
      q_nxt.evt[EVT_OVF] = 1'b1;                  // [RULE15]
    end
    if (access & ~PWRITE & reg_hit(PADDR, ADDR_DATA)
        & (q_r.count == COUNT_RST)) begin
      q_nxt.evt[EVT_UDF] = 1'b1;                  // [RULE15]
    end

    // Level interrupt from the values about to be stored
    q_nxt.irq = |(q_nxt.evt & q_nxt.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Empty at reset, so the near-empty history starts high
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      q_r.st        <= ST_IDLE;
      q_r.prdata    <= 32'h0000_0000;
      q_r.pready    <= 1'b0;
      q_r.pslverr   <= 1'b0;
      q_r.irq       <= 1'b0;
      q_r.depth_sel <= CFG_DEPTH_RST;
      q_r.thr_msb   <= CFG_TMSB_RST;
      q_r.thr_low   <= THRESH_RST;
      q_r.count     <= COUNT_RST;                 // [RULE9]
      q_r.wr_ptr    <= 9'h000;
      q_r.rd_ptr    <= 9'h000;
      q_r.evt       <= 4'h0;
      q_r.mask      <= MASK_RST;
      q_r.nf_prev   <= 1'b0;
      q_r.ne_prev   <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign PRDATA     = q_r.prdata;
  assign PREADY     = q_r.pready;
  assign PSLVERR    = q_r.pslverr;
  assign NEAR_FULL  = q_r.nf_prev;
  assign NEAR_EMPTY = q_r.ne_prev;
  assign IRQ        = q_r.irq;

endmodule
`default_nettype wire

// ==== sim/apb_host.sv ====
// Host model issuing APB transfers to the register block
`timescale 1ns/1ps
`default_nettype none
module apb_host
  import byte_fifo_pkg::*;
(
  // Clock
  input  wire logic        MCLK,
  // Answer
  input  wire logic [31:0] PRDATA,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR,
  // Request
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic      [7:0]  PADDR,
  output logic      [31:0] PWDATA,
  output logic      [3:0]  PSTRB
);
  logic hung = 1'b0;
  // Idle bus from time zero
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    PSTRB = 4'h1;
  end
  // One transfer; the data port address is simply reused, never stepped
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge MCLK);
      if (PREADY === 1'b1) begin
        break;
      end
    end
    hung = (n == 16);
    q = PRDATA[7:0];
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Idle cycle keeps each signal to one assignment per step
    @(posedge MCLK);
  endtask
endmodule
`default_nettype wire

// ==== sim/byte_fifo_checker.sv ====
// Port-level assertions for the byte FIFO register block
`timescale 1ns/1ps
`default_nettype none
module byte_fifo_checker
  import byte_fifo_pkg::*;
(
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST_B,
  // APB request
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  // APB answer
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Flags and interrupt
  input wire logic        NEAR_FULL,
  input wire logic        NEAR_EMPTY,
  input wire logic        IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  // ------------------------------------------------------------
  // Completed write steps
  // ------------------------------------------------------------
  wire logic wr_done = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  sequence s_flush;
    wr_done && PADDR == ADDR_CONFIG && PWDATA[CFG_CLEAR_BIT];
  endsequence
  sequence s_mask_off;
    wr_done && PADDR == ADDR_MASK && PWDATA[3:0] == 4'h0;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_setup_ready: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  chk_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  chk_idle_quiet: assert property (!PSEL |-> !PREADY && !PSLVERR)
    else $error("answer while idle");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("error read not zero");
  chk_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_flush_empty: assert property (s_flush |-> ##[1:2] NEAR_EMPTY)
    else $error("flush left buffer filled");
  chk_mask_irq: assert property (s_mask_off |=> !IRQ)
    else $error("irq with all masked");
endmodule
bind rf_frontend_byte_fifo byte_fifo_checker u_byte_fifo_checker (
  .MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .NEAR_FULL(NEAR_FULL), .NEAR_EMPTY(NEAR_EMPTY), .IRQ(IRQ)
);
`default_nettype wire

// ==== sim/tb_rf_frontend_byte_fifo.sv ====
// Register-level testbench for the byte FIFO block
`timescale 1ns/1ps
`default_nettype none
module tb_rf_frontend_byte_fifo
  import byte_fifo_pkg::*;
;
  logic        MCLK;
  logic        RST_B;
  logic        PSEL, PENABLE, PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0]  PSTRB;
  logic        PREADY, PSLVERR, NEAR_FULL, NEAR_EMPTY, IRQ;
  logic [7:0]  q;
  logic        e;
  int          num_errors = 0;
  int          checks_done = 0;

  rf_frontend_byte_fifo u_rf_frontend_byte_fifo (
    .MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .NEAR_FULL(NEAR_FULL), .NEAR_EMPTY(NEAR_EMPTY), .IRQ(IRQ));
  apb_host u_apb_host (
    .MCLK(MCLK), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB));

  // ------------------------------------------------------------
  // Clock and helpers
  // ------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  task automatic finish_test();
    $display("Counts: %0d mismatches in %0d checks", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // A hung bus counts as a mismatch and ends the run
  task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
    u_apb_host.xfer(w, a, d, q, e);
    if (u_apb_host.hung) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic push(input int n, input logic [7:0] b);
    for (int k = 0; k < n; k++) begin
      xf(1'b1, ADDR_DATA, b + 8'(k));
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    RST_B = 1'b0;
    repeat (8) @(posedge MCLK);
    RST_B <= 1'b1;
    @(posedge MCLK);
    xf(1'b0, ADDR_CONFIG, 8'h0);
    chk(q, 8'h20);
    chk({7'h0, NEAR_EMPTY}, 8'h01);
    chk({7'h0, NEAR_FULL}, 8'h00);
    xf(1'b0, ADDR_COUNT, 8'h0);
    chk(q, 8'h00);
    xf(1'b1, ADDR_THRESH, 8'ha5);
    xf(1'b0, ADDR_THRESH, 8'h0);
    chk(q, 8'ha5);
    xf(1'b0, 8'h3c, 8'h0);
    chk(q, 8'h00);
    chk({7'h0, e}, 8'h01);
    $display("test reset and map done");
    // Order and count through one fixed address, near-empty event
    xf(1'b1, ADDR_THRESH, 8'h03);
    push(5, 8'h30);
    xf(1'b0, ADDR_COUNT, 8'h0);
    chk(q, 8'h05);
    xf(1'b0, ADDR_CONFIG, 8'h0);
    chk(q, 8'h00);
    chk({7'h0, NEAR_EMPTY}, 8'h00);
    xf(1'b1, ADDR_MASK, 8'h01);
    for (int k = 0; k < 5; k++) begin
      xf(1'b0, ADDR_DATA, 8'h0);
      chk(q, 8'h30 + 8'(k));
    end
    xf(1'b0, ADDR_EVENT, 8'h0);
    chk(q, 8'h01);
    chk({7'h0, IRQ}, 8'h01);
    xf(1'b1, ADDR_EVENT, 8'h01);
    xf(1'b0, ADDR_DATA, 8'h0);
    chk(q, 8'h00);
    xf(1'b0, ADDR_COUNT, 8'h0);
    chk(q, 8'h00);
    xf(1'b0, ADDR_EVENT, 8'h0);
    chk(q, 8'h08);
    chk({7'h0, IRQ}, 8'h00);
    $display("test stream and interrupt done");
    // Small depth: extension bit ignored, near-full, overflow
    xf(1'b1, ADDR_MASK, 8'h00);
    xf(1'b1, ADDR_CONFIG, 8'h94);
    xf(1'b1, ADDR_THRESH, 8'h00);
    xf(1'b1, ADDR_EVENT, 8'h0f);
    push(10, 8'h00);
    xf(1'b0, ADDR_CONFIG, 8'h0);
    chk(q, 8'h84);
    xf(1'b1, ADDR_THRESH, 8'h02);
    push(243, 8'h00);
    xf(1'b0, ADDR_CONFIG, 8'h0);
    chk(q, 8'hc4);
    chk({7'h0, NEAR_FULL}, 8'h01);
    xf(1'b0, ADDR_EVENT, 8'h0);
    chk(q, 8'h02);
    push(3, 8'h00);
    xf(1'b0, ADDR_COUNT, 8'h0);
    chk(q, 8'hff);
    xf(1'b0, ADDR_EVENT, 8'h0);
    chk(q, 8'h06);
    $display("test small depth done");
    // Large depth with threshold bit 8 and count bits 9:8
    xf(1'b1, ADDR_CONFIG, 8'h14);
    xf(1'b1, ADDR_THRESH, 8'h00);
    xf(1'b0, ADDR_EVENT, 8'h0);
    chk(q, 8'h07);
    push(256, 8'h00);
    xf(1'b0, ADDR_CONFIG, 8'h0);
    chk(q, 8'h65);
    push(256, 8'h00);
    xf(1'b0, ADDR_COUNT, 8'h0);
    chk(q, 8'h00);
    xf(1'b0, ADDR_CONFIG, 8'h0);
    chk(q, 8'h46);
    xf(1'b1, ADDR_CONFIG, 8'h10);
    xf(1'b0, ADDR_CONFIG, 8'h0);
    chk(q, 8'h20);
    xf(1'b0, ADDR_COUNT, 8'h0);
    chk(q, 8'h00);
    $display("test large depth and flush done");
    finish_test();
  end
endmodule
`default_nettype wire
